// file: verilog/wdog_pkg.sv
// Package: timing constants and state encoding of the windowed watchdog sequencer
package wdog_pkg;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ            = 50_000_000;
  localparam int unsigned TICK_US           = 100;
  localparam int unsigned TICK_DIV          = (CLK_HZ / 1_000_000) * TICK_US;
  localparam int unsigned TICK_DIV_W        = 13;

  // ----------------------------------------------------------------
  // Phase times in microseconds, with tick counts derived from them
  // ----------------------------------------------------------------
  localparam int unsigned POWER_ON_DELAY_US       = 100_000;
  localparam int unsigned CLOSED_WINDOW_TIME_US   = 80_000;
  localparam int unsigned OPEN_WINDOW_TIME_US     = 40_000;
  localparam int unsigned WD_RESET_PULSE_WIDTH_US = 2_500;
  localparam int unsigned POR_TICKS          = POWER_ON_DELAY_US / TICK_US;
  localparam int unsigned CLOSED_TICKS       = CLOSED_WINDOW_TIME_US / TICK_US;
  localparam int unsigned OPEN_TICKS         = OPEN_WINDOW_TIME_US / TICK_US;
  localparam int unsigned WDR_TICKS          = WD_RESET_PULSE_WIDTH_US / TICK_US;
  localparam int unsigned PHASE_CNT_W        = 12;

  // ----------------------------------------------------------------
  // Consecutive good services needed before enable goes active
  // ----------------------------------------------------------------
  localparam logic [1:0]  GOOD_SERVICES_NEEDED = 2'h3;

  typedef enum logic [4:0] {
    ST_SUPPLY_LOW = 5'h01,
    ST_POR        = 5'h02,
    ST_CLOSED     = 5'h04,
    ST_OPEN       = 5'h08,
    ST_WD_RESET   = 5'h10
  } wd_state_t;

endpackage

// file: verilog/tick_divider.sv
// Tick divider: one-cycle enable pulse for the watchdog time base
`timescale 1ns/100ps
module tick_divider
  import wdog_pkg::*;
#(
  parameter int unsigned DIV = TICK_DIV
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Tick output
  output logic      tick
);

  logic [TICK_DIV_W-1:0] cnt_r;
  wire                   wrap = (cnt_r == TICK_DIV_W'(DIV - 1));

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cnt_r <= '0;
      tick  <= 1'b0;
    end else begin
      cnt_r <= wrap ? '0 : cnt_r + 1'b1;
      tick  <= wrap;
    end
  end

endmodule

// file: verilog/windowed_watchdog_enable.sv
// Windowed watchdog sequencer with power-on delay and system enable output
`timescale 1ns/100ps

module windowed_watchdog_enable
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DIV
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic sys_rst,
  // Supply monitor and host service pin
  input  wire logic supply_good,
  input  wire logic service_pulse_in_n,
  // Outputs to the system
  output logic      sys_reset_out_n,
  output logic      sys_enable_out_n
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic       sg_meta_r;
  logic       sg_sync_r;
  logic       svc_meta_r;
  logic       svc_sync_r;
  logic       svc_prev_r;

  // Both pins are asynchronous to clock; supply reads bad until proven good
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sg_meta_r <= 1'b0;
      sg_sync_r <= 1'b0;
    end else begin
      sg_meta_r <= supply_good;
      sg_sync_r <= sg_meta_r;
    end
  end

  // Edge register starts at the idle level, so reset makes no false edge
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      svc_meta_r <= 1'b1;
      svc_sync_r <= 1'b1;
      svc_prev_r <= 1'b1;
    end else begin
      svc_meta_r <= service_pulse_in_n;
      svc_sync_r <= svc_meta_r;
      svc_prev_r <= svc_sync_r;
    end
  end

  // Service is counted on the falling edge of the active-low pin
  wire svc_fall = svc_prev_r & ~svc_sync_r;

  // ----------------------------------------------------------------
  // Time base
  // ----------------------------------------------------------------
  logic tick;

  // Free-running from reset: a phase may end up to one tick short
  tick_divider #(
    .DIV     (TICK_CYCLES)
  ) u_tick (
    .clock   (clock),
    .sys_rst (sys_rst),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  wd_state_t              state_r;
  wd_state_t              state_nxt;
  logic [PHASE_CNT_W-1:0] cnt_r;
  logic [PHASE_CNT_W-1:0] cnt_nxt;
  logic [1:0]             good_r;
  logic [1:0]             good_nxt;
  logic                   reset_n_nxt;
  logic                   enable_n_nxt;

  // Last tick of a phase of given length
  function automatic logic phase_done(input logic [PHASE_CNT_W-1:0] c, input int unsigned len);
    phase_done = (c == PHASE_CNT_W'(len - 1));
  endfunction

  // Timeouts end a phase only on a tick, so all timing is in ticks
  wire por_end    = tick & phase_done(cnt_r, POR_TICKS);
  wire closed_end = tick & phase_done(cnt_r, CLOSED_TICKS);
  wire open_end   = tick & phase_done(cnt_r, OPEN_TICKS);
  wire wdr_end    = tick & phase_done(cnt_r, WDR_TICKS);
  wire [PHASE_CNT_W-1:0] cnt_step = tick ? cnt_r + 1'b1 : cnt_r;
  // Loss is seen two clocks late, after the synchroniser
  wire                   supply_lost = ~sg_sync_r;

  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_step;
    good_nxt  = good_r;
    case (state_r)
      ST_SUPPLY_LOW: begin
        // Counter held at zero so the delay starts whole
        cnt_nxt = '0;
        if (sg_sync_r) begin
          state_nxt = ST_POR;
        end
      end
      ST_POR: begin
        // Service edges not examined here
        if (por_end) begin
          state_nxt = ST_CLOSED;
          cnt_nxt   = '0;
        end
      end
      ST_CLOSED: begin
        // Too early: a fault, not a service
        if (svc_fall) begin
          state_nxt = ST_WD_RESET;
          cnt_nxt   = '0;
        end else if (closed_end) begin
          state_nxt = ST_OPEN;
          cnt_nxt   = '0;
        end
      end
      ST_OPEN: begin
        if (svc_fall) begin
          state_nxt = ST_CLOSED;
          cnt_nxt   = '0;
          // Saturates, so later services keep enable active
          if (good_r != GOOD_SERVICES_NEEDED) begin
            good_nxt = good_r + 1'b1;
          end
        end else if (open_end) begin
          state_nxt = ST_WD_RESET;
          cnt_nxt   = '0;
        end
      end
      ST_WD_RESET: begin
        // Service edges during the pulse are ignored
        good_nxt = '0;
        if (wdr_end) begin
          // Loop repeats closed, open, pulse while unserviced
          state_nxt = ST_CLOSED;
          cnt_nxt   = '0;
        end
      end
      default: begin
        state_nxt = ST_SUPPLY_LOW;
        cnt_nxt   = '0;
        good_nxt  = '0;
      end
    endcase
    // Supply loss overrides everything, even mid-phase
    if (supply_lost) begin
      state_nxt = ST_SUPPLY_LOW;
      cnt_nxt   = '0;
      good_nxt  = '0;
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // States in which the system is held in reset
  function automatic logic holds_reset(input wd_state_t s);
    case (s)
      ST_SUPPLY_LOW: holds_reset = 1'b1;
      ST_POR:        holds_reset = 1'b1;
      ST_WD_RESET:   holds_reset = 1'b1;
      default:       holds_reset = 1'b0;
    endcase
  endfunction

  // Outputs registered from next state so they track it the same edge
  wire in_reset_nxt = holds_reset(state_nxt);
  assign reset_n_nxt  = ~in_reset_nxt;
  assign enable_n_nxt = in_reset_nxt | (good_nxt != GOOD_SERVICES_NEEDED);

  // Sequencer state
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r <= ST_SUPPLY_LOW;
      cnt_r   <= '0;
      good_r  <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      good_r  <= good_nxt;
    end
  end

  // Held in reset, enable inactive, until the sequencer says otherwise
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sys_reset_out_n  <= 1'b0;
      sys_enable_out_n <= 1'b1;
    end else begin
      sys_reset_out_n  <= reset_n_nxt;
      sys_enable_out_n <= enable_n_nxt;
    end
  end

endmodule

// file: dv/wdog_properties.sv
// Checker: port timing relations of the windowed watchdog sequencer
`timescale 1ns/100ps
module wdog_properties
  import wdog_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_DIV
) (
  // Clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // Watched pins
  input wire logic supply_good,
  input wire logic service_pulse_in_n,
  input wire logic sys_reset_out_n,
  input wire logic sys_enable_out_n
);
  int unsigned lo_n, hi_n, svc_n;
  // Cycle counters; tick phase jitter is why bounds allow one tick short per closed window, two on the reset pulse
  always_ff @(posedge clock) begin
    lo_n  <= sys_reset_out_n ? 0 : lo_n + 1;
    hi_n  <= sys_reset_out_n ? hi_n + 1 : 0;
    svc_n <= $fell(service_pulse_in_n) ? 0 : svc_n + 1;
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_drop; supply_good ##1 !supply_good; endsequence
  a_enable_off_reset: assert property (!sys_reset_out_n |-> sys_enable_out_n)
    else $error("enable active while reset asserted");
  a_loss_resets: assert property (s_drop |-> ##[0:4] !sys_reset_out_n)
    else $error("supply loss did not assert reset");
  a_low_supply_holds: assert property ((!supply_good)[*6] |-> !sys_reset_out_n)
    else $error("reset released with supply low");
  a_por_holds_reset: assert property ($rose(supply_good) |-> ##1 (!sys_reset_out_n)[*8])
    else $error("reset released at supply rise");
  a_release_cause: assert property ($rose(sys_reset_out_n) |-> $past(supply_good, 4))
    else $error("reset released without supply");
  a_pulse_width_min: assert property ($rose(sys_reset_out_n) |-> lo_n >= (WDR_TICKS - 2) * TICK_CYCLES)
    else $error("reset pulse too short");
  a_enable_after_three: assert property ($fell(sys_enable_out_n) |-> hi_n >= 3 * (CLOSED_TICKS - 1) * TICK_CYCLES)
    else $error("enable active too soon after reset");
  a_enable_on_service: assert property ($fell(sys_enable_out_n) |-> svc_n <= 8)
    else $error("enable active without service edge");
  a_release_enable_off: assert property ($rose(sys_reset_out_n) |-> sys_enable_out_n)
    else $error("enable active at reset release");
endmodule

bind windowed_watchdog_enable wdog_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (.clock(clock),
  .sys_rst(sys_rst), .supply_good(supply_good), .service_pulse_in_n(service_pulse_in_n),
  .sys_reset_out_n(sys_reset_out_n), .sys_enable_out_n(sys_enable_out_n));

// file: dv/host_model.sv
// Host model: drives the active-low service pin on request
`timescale 1ns/100ps
module host_model (
  // Clock and request
  input  wire logic clock,
  input  wire logic svc_req,
  // Service pin, idles high as if pulled up
  output logic      service_pulse_in_n
);
  logic [2:0] hold_r = 3'h0;
  // Four clocks low so the pin synchroniser cannot miss it
  always_ff @(posedge clock) begin
    if (svc_req) hold_r <= 3'h4;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
  end
  assign service_pulse_in_n = (hold_r == 3'h0);
endmodule

// file: dv/tb_windowed_watchdog_enable.sv
// Testbench: scenario driver and output monitor of the watchdog sequencer
`timescale 1ns/100ps
module tb_windowed_watchdog_enable import wdog_pkg::*; ;
  localparam int unsigned TC = 4;
  localparam int unsigned CW = CLOSED_TICKS * TC;
  localparam int unsigned OW = OPEN_TICKS * TC;
  logic       clock = 1'b0;
  logic       sys_rst;
  logic       supply_good;
  logic       svc_req;
  logic       armed = 1'b0;
  logic       service_pulse_in_n, sys_reset_out_n, sys_enable_out_n;
  logic [1:0] exp_q[$];
  int         failures = 0;
  int         checks_done = 0;
  always #10 clock = ~clock;
  host_model host (.clock(clock), .svc_req(svc_req), .service_pulse_in_n(service_pulse_in_n));
  windowed_watchdog_enable #(.TICK_CYCLES(TC)) dut (.clock(clock), .sys_rst(sys_rst), .supply_good(supply_good),
    .service_pulse_in_n(service_pulse_in_n), .sys_reset_out_n(sys_reset_out_n), .sys_enable_out_n(sys_enable_out_n));
  task automatic check_outs(input logic [1:0] exp, input logic [1:0] seen);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] reset_n/enable_n expected %b seen %b", exp, seen);
    end
  endtask
  // Any output change with no note queued is a mismatch
  always @(sys_reset_out_n or sys_enable_out_n) begin
    if (armed) begin
      #1;
      if (exp_q.size() == 0) check_outs(2'bxx, {sys_reset_out_n, sys_enable_out_n});
      else check_outs(exp_q.pop_front(), {sys_reset_out_n, sys_enable_out_n});
    end
  end
  task automatic tick(input int unsigned n);
    repeat (n) @(negedge clock);
  endtask
  task automatic serve(input int unsigned dly);
    tick(dly);
    svc_req = 1'b1;
    tick(1);
    svc_req = 1'b0;
  endtask
  task automatic settle(input string name);
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 12000) begin
      tick(1);
      n++;
    end
    if (exp_q.size() != 0) begin
      failures++;
      $display("[FAIL] %s pending notes expected 0 seen %0d", name, exp_q.size());
    end
    exp_q.delete();
    $display("test %s done", name);
  endtask
  // Services land at a random point well inside the open window
  task automatic three_good(input string name);
    for (int i = 0; i < 3; i++) begin
      if (i == 2) exp_q.push_back(2'b10);
      serve(CW + 16 + $urandom_range(OW - 40));
    end
    settle(name);
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    supply_good = 1'b0;
    svc_req = 1'b0;
    void'($urandom(71));
    tick(20);
    sys_rst = 1'b0;
    armed = 1'b1;
    tick(2);
    exp_q.push_back(2'b11);
    supply_good = 1'b1;
    serve(1000);
    settle("power_up");
    three_good("three_services");
    exp_q.push_back(2'b01);
    exp_q.push_back(2'b11);
    serve(100);
    settle("premature");
    three_good("count_cleared");
    repeat (2) begin
      exp_q.push_back(2'b01);
      exp_q.push_back(2'b11);
    end
    settle("missed_windows");
    three_good("recovery");
    exp_q.push_back(2'b01);
    exp_q.push_back(2'b11);
    supply_good = 1'b0;
    serve(50);
    supply_good = 1'b1;
    serve(2000);
    settle("supply_loss");
    print_verdict();
  end
  initial begin
    #(90000 * 20);
    failures++;
    print_verdict();
  end
endmodule
